// >>> code_to_signed.sv
`timescale 1ns/100ps
`default_nettype none
// maps a 10-bit two's-complement code to a signed numerator over 500
module code_to_signed
    import motor_dbg_pkg::*;
(
    input  wire logic [FIELD_W-1:0] code_i,
    output logic signed [FIELD_W:0] num_o,
    output logic                    valid_o
);
    // 501..511 is the gap; treated as zero and flagged invalid, never written by good software
    always_comb begin
        num_o   = '0;
        valid_o = 1'b1;
        if (code_i < POS_LIMIT) begin
            num_o = $signed({1'b0, code_i});
        end else if (code_i > NEG_LIMIT) begin
            num_o = $signed({1'b0, code_i} - WRAP_VALUE);
        end else if (code_i != POS_LIMIT && code_i != NEG_LIMIT) begin
            valid_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> motor_algo_debug_override_regs.sv
`timescale 1ns/100ps
`default_nettype none
// debug override registers of the field-oriented control algorithm
module motor_algo_debug_override_regs
    import motor_dbg_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [31:0]              reg_wdata_i,
    output logic [31:0]                   reg_rdata_o,
    input  wire logic [SCALE_W-1:0]       scale_a_i,
    input  wire logic [15:0]              cfg_align_angle_i,
    input  wire logic [15:0]              override_align_angle_i,
    input  wire logic                     speed_loop_off_i,
    input  wire logic                     measure_busy_i,
    output logic [15:0]                   align_angle_o,
    output logic                          speed_loop_off_o,
    output logic                          current_loop_off_o,
    output logic                          torque_ref_override_o,
    output logic signed [REF_W+SCALE_W-1:0] torque_current_ref_o,
    output logic signed [FIELD_W:0]       d_axis_voltage_num_o,
    output logic signed [FIELD_W:0]       q_axis_voltage_num_o,
    output logic                          param_measure_start_o,
    output logic                          measure_resistance_en_o,
    output logic                          measure_inductance_en_o,
    output logic                          measure_backemf_const_en_o,
    output logic                          measure_mechanical_en_o,
    output logic                          measured_to_shadow_write_o,
    output logic                          code_invalid_o
);
    typedef struct packed {
        logic [31:0]              dbg1;
        logic [31:0]              dbg2;
        logic [31:0]              rdata;
        logic                     start_p;
        logic                     shadow_p;
        logic [15:0]              angle;
        logic signed [REF_W+SCALE_W-1:0] iq_ref;
        logic signed [FIELD_W:0]  vd;
        logic signed [FIELD_W:0]  vq;
        logic                     bad;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic signed [FIELD_W:0]          iq_num;
    logic signed [FIELD_W:0]          vd_num;
    logic signed [FIELD_W:0]          vq_num;
    logic                             iq_ok;
    logic                             vd_ok;
    logic                             vq_ok;
    logic signed [REF_W+SCALE_W-1:0]  iq_scaled;

    logic        [FIELD_W-1:0]        fld_code [3];
    logic signed [FIELD_W:0]          fld_num  [3];
    logic                             fld_ok   [3];

    // forced reference fields: torque current, d-axis, q-axis
    assign fld_code[0] = st_r.dbg1[IQ_LSB +: FIELD_W];
    assign fld_code[1] = st_r.dbg2[VD_LSB +: FIELD_W];
    assign fld_code[2] = st_r.dbg2[VQ_LSB +: FIELD_W];

    // one decoder per forced reference field
    for (genvar g = 0; g < 3; g++) begin : g_dec
        code_to_signed u_dec (
            .code_i  (fld_code[g]),
            .num_o   (fld_num[g]),
            .valid_o (fld_ok[g])
        );
    end

    // decoded numerators and validity, named per field
    assign iq_num = fld_num[0];
    assign vd_num = fld_num[1];
    assign vq_num = fld_num[2];
    assign iq_ok  = fld_ok[0];
    assign vd_ok  = fld_ok[1];
    assign vq_ok  = fld_ok[2];
    ref_scaler u_iq_scale (
        .num_i   (iq_num),
        .scale_i (scale_a_i),
        .ref_o   (iq_scaled)
    );

    logic wr1;
    logic wr2;
    logic loop_cur_off;

    // register select, shared by the write and read decodes
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] offs);
        return addr == offs;
    endfunction

    // register writes, one-shot commands and registered outputs
    always_comb begin
        st_nxt          = st_r;
        wr1             = reg_wr_i && addr_hit(reg_addr_i, DBG1_OFFSET);
        wr2             = reg_wr_i && addr_hit(reg_addr_i, DBG2_OFFSET);
        st_nxt.start_p  = 1'b0;
        st_nxt.shadow_p = 1'b0;
        if (wr1) begin
            st_nxt.dbg1 = reg_wdata_i;
        end
        if (wr2) begin
            st_nxt.dbg2 = reg_wdata_i & DBG2_WRITE_MASK;
            st_nxt.start_p  = reg_wdata_i[MEAS_START_BIT];
            st_nxt.shadow_p = reg_wdata_i[SHADOW_WR_BIT];
        end
        // first register is write-only; second reads back its fields
        st_nxt.rdata = '0;
        if (reg_rd_i && addr_hit(reg_addr_i, DBG2_OFFSET)) begin
            st_nxt.rdata = st_r.dbg2 & DBG2_WRITE_MASK;
        end
        st_nxt.angle = st_r.dbg1[ALIGN_SEL_BIT] ? override_align_angle_i
                                                : cfg_align_angle_i;
        loop_cur_off = st_r.dbg2[CUR_OFF_BIT];
        // rule 3 and 4 via decoder; torque ref zero unless speed loop is off, voltages zero unless current loop is off
        st_nxt.iq_ref = (speed_loop_off_i || loop_cur_off)
                        ? iq_scaled : '0;
        st_nxt.vd = loop_cur_off ? vd_num : '0;
        st_nxt.vq = loop_cur_off ? vq_num : '0;
        // flags gap codes; software must avoid them
        st_nxt.bad = !iq_ok || !vd_ok || !vq_ok;
    end

    // single state register, frozen when clock enable is low except during reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r       <= '0;
            st_r.dbg1  <= DBG1_RESET;
            st_r.dbg2  <= DBG2_RESET;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign reg_rdata_o                = st_r.rdata;
    assign align_angle_o              = st_r.angle;
    assign current_loop_off_o         = st_r.dbg2[CUR_OFF_BIT];
    assign speed_loop_off_o           = speed_loop_off_i
                                        || st_r.dbg2[CUR_OFF_BIT];
    assign torque_ref_override_o      = speed_loop_off_o;
    assign torque_current_ref_o       = st_r.iq_ref;
    assign d_axis_voltage_num_o       = st_r.vd;
    assign q_axis_voltage_num_o       = st_r.vq;
    // start ignored while a run is busy: avoids restart mid-measurement
    assign param_measure_start_o      = st_r.start_p && !measure_busy_i;
    assign measure_resistance_en_o    = st_r.dbg2[MEAS_R_BIT];
    assign measure_inductance_en_o    = st_r.dbg2[MEAS_L_BIT];
    assign measure_backemf_const_en_o = st_r.dbg2[MEAS_KE_BIT];
    assign measure_mechanical_en_o    = st_r.dbg2[MEAS_MECH_BIT];
    assign measured_to_shadow_write_o = st_r.shadow_p;
    assign code_invalid_o             = st_r.bad;
endmodule
`default_nettype wire

// >>> motor_dbg_pkg.sv
package motor_dbg_pkg;
    localparam logic [7:0]  DBG1_OFFSET      = 8'hec;
    localparam logic [7:0]  DBG2_OFFSET      = 8'hee;
    localparam logic [31:0] DBG1_RESET       = 32'h0000_0000;
    localparam logic [31:0] DBG2_RESET       = 32'h0000_0000;
    localparam int          ALIGN_SEL_BIT    = 10;
    localparam int          IQ_LSB           = 0;
    localparam int          CUR_OFF_BIT      = 26;
    localparam int          VD_LSB           = 16;
    localparam int          VQ_LSB           = 6;
    localparam int          MEAS_START_BIT   = 5;
    localparam int          MEAS_R_BIT       = 4;
    localparam int          MEAS_L_BIT       = 3;
    localparam int          MEAS_KE_BIT      = 2;
    localparam int          MEAS_MECH_BIT    = 1;
    localparam int          SHADOW_WR_BIT    = 0;
    localparam logic [31:0] DBG2_WRITE_MASK  = 32'h07ff_ffff;
    localparam logic [9:0]  POS_LIMIT        = 10'h1f4; // 500
    localparam logic [9:0]  NEG_LIMIT        = 10'h200; // 512
    localparam logic [10:0] WRAP_VALUE       = 11'h400; // 1024
    localparam logic [9:0]  FULL_SCALE       = 10'h1f4; // divisor 500
    localparam int          FIELD_W          = 10;
    localparam int          SCALE_W          = 16;
    localparam int          REF_W            = 18;
endpackage

// >>> motor_dbg_sva.sv
`timescale 1ns/100ps
`default_nettype none
// watches the debug override block from its ports
module motor_dbg_sva
    import motor_dbg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic speed_loop_off_i,
    input wire logic measure_busy_i,
    input wire logic speed_loop_off_o,
    input wire logic current_loop_off_o,
    input wire logic signed [FIELD_W:0] d_axis_voltage_num_o,
    input wire logic signed [FIELD_W:0] q_axis_voltage_num_o,
    input wire logic param_measure_start_o,
    input wire logic measure_resistance_en_o,
    input wire logic measure_inductance_en_o,
    input wire logic measure_backemf_const_en_o,
    input wire logic measure_mechanical_en_o,
    input wire logic measured_to_shadow_write_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a write to the second register taken at this edge
    sequence s_wr2;
        ce_i && reg_wr_i && reg_addr_i == 8'hee;
    endsequence
    a_cur_off_wr: assert property (
        s_wr2 |=> current_loop_off_o == $past(reg_wdata_i[26]))
        else $error("loop off bit not taken");
    a_start_pulse: assert property (
        s_wr2 ##0 reg_wdata_i[5] |=> param_measure_start_o == !measure_busy_i)
        else $error("start pulse missing");
    a_start_cause: assert property (
        param_measure_start_o && $past(ce_i) |->
        $past(reg_wr_i && reg_addr_i == 8'hee && reg_wdata_i[5]))
        else $error("start pulse without write");
    a_shadow_pulse: assert property (
        s_wr2 ##0 reg_wdata_i[0] |=> measured_to_shadow_write_o)
        else $error("shadow copy pulse missing");
    a_speed_follow: assert property (
        speed_loop_off_o == (speed_loop_off_i || current_loop_off_o))
        else $error("speed loop off wrong");
    a_volt_idle: assert property (
        ce_i && !current_loop_off_o |=> d_axis_voltage_num_o == 0
        && q_axis_voltage_num_o == 0) else $error("voltage not idle");
    a_meas_en: assert property (
        s_wr2 |=> {measure_resistance_en_o, measure_inductance_en_o,
        measure_backemf_const_en_o, measure_mechanical_en_o}
        == $past(reg_wdata_i[4:1])) else $error("enable bits wrong");
    a_resv_read: assert property (
        ce_i && reg_rd_i && reg_addr_i == 8'hee |=> reg_rdata_o[31:27] == 0)
        else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// >>> ref_scaler.sv
`timescale 1ns/100ps
`default_nettype none
// forms num * scale / 500 as a signed fixed-point reference
module ref_scaler
    import motor_dbg_pkg::*;
(
    input  wire logic signed [FIELD_W:0]   num_i,
    input  wire logic        [SCALE_W-1:0] scale_i,
    output logic signed      [REF_W+SCALE_W-1:0] ref_o
);
    logic signed [FIELD_W+SCALE_W+1:0] prod;
    // division kept combinational: the loops update slowly at 10 MHz
    always_comb begin
        prod  = num_i * $signed({1'b0, scale_i});
        ref_o = (REF_W+SCALE_W)'(prod / $signed({1'b0, FULL_SCALE}));
    end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import motor_dbg_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic speed_loop_off_i = 0, measure_busy_i = 0;
    logic [7:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o;
    logic [15:0] scale_a_i = 0, align_angle_o;
    logic [15:0] cfg_align_angle_i = 16'h1234;
    logic [15:0] override_align_angle_i = 16'h0abc;
    logic speed_loop_off_o, current_loop_off_o, torque_ref_override_o;
    logic param_measure_start_o, measured_to_shadow_write_o;
    logic measure_resistance_en_o, measure_inductance_en_o;
    logic measure_backemf_const_en_o, measure_mechanical_en_o;
    logic code_invalid_o;
    logic signed [REF_W+SCALE_W-1:0] torque_current_ref_o;
    logic signed [FIELD_W:0] d_axis_voltage_num_o, q_axis_voltage_num_o;
    int n_mismatch = 0, n_checks = 0;
    motor_algo_debug_override_regs uut (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .ce_i                       (ce_i),
        .reg_addr_i                 (reg_addr_i),
        .reg_wr_i                   (reg_wr_i),
        .reg_rd_i                   (reg_rd_i),
        .reg_wdata_i                (reg_wdata_i),
        .reg_rdata_o                (reg_rdata_o),
        .scale_a_i                  (scale_a_i),
        .cfg_align_angle_i          (cfg_align_angle_i),
        .override_align_angle_i     (override_align_angle_i),
        .speed_loop_off_i           (speed_loop_off_i),
        .measure_busy_i             (measure_busy_i),
        .align_angle_o              (align_angle_o),
        .speed_loop_off_o           (speed_loop_off_o),
        .current_loop_off_o         (current_loop_off_o),
        .torque_ref_override_o      (torque_ref_override_o),
        .torque_current_ref_o       (torque_current_ref_o),
        .d_axis_voltage_num_o       (d_axis_voltage_num_o),
        .q_axis_voltage_num_o       (q_axis_voltage_num_o),
        .param_measure_start_o      (param_measure_start_o),
        .measure_resistance_en_o    (measure_resistance_en_o),
        .measure_inductance_en_o    (measure_inductance_en_o),
        .measure_backemf_const_en_o (measure_backemf_const_en_o),
        .measure_mechanical_en_o    (measure_mechanical_en_o),
        .measured_to_shadow_write_o (measured_to_shadow_write_o),
        .code_invalid_o             (code_invalid_o)
    );
    // 100 ns period clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task chk(input string nm, input logic signed [33:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // inputs move only on the falling edge, taken on the next rising edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        tick(1);
        reg_wr_i = 0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        reg_addr_i = a;
        reg_rd_i = 1;
        tick(1);
        reg_rd_i = 0;
        chk("rdata", reg_rdata_o, e);
    endtask
    task t_volt;
        wr(8'hee, {5'h1f, 1'b1, 10'h3e8, 10'h0fa, 6'h00});
        chk("spd", speed_loop_off_o, 1);
        chk("cur", current_loop_off_o, 1);
        chk("ovr", torque_ref_override_o, 1);
        tick(1);
        chk("vd", d_axis_voltage_num_o, -24);
        chk("vq", q_axis_voltage_num_o, 250);
        rd_chk(8'hee, 32'h07e8_3e80);
        wr(8'hee, {6'h01, 10'h1f3, 10'h3e8, 6'h00});
        tick(1);
        chk("vd", d_axis_voltage_num_o, 499);
        chk("vq", q_axis_voltage_num_o, -24);
        wr(8'hee, {6'h00, 10'h1f9, 16'h0000});
        tick(2);
        chk("inv", code_invalid_o, 1);
        chk("vd", d_axis_voltage_num_o, 0);
        chk("cur", current_loop_off_o, 0);
    endtask
    task t_torque;
        scale_a_i = 16'd500;
        speed_loop_off_i = 1;
        wr(8'hec, {21'h0, 1'b1, 10'h3e8});
        chk("ovr", torque_ref_override_o, 1);
        tick(1);
        chk("iq", torque_current_ref_o, -24);
        chk("ang", align_angle_o, 16'h0abc);
        scale_a_i = 16'd1000;
        wr(8'hec, 32'h0000_0064);
        tick(1);
        chk("iq", torque_current_ref_o, 200);
        chk("ang", align_angle_o, 16'h1234);
        speed_loop_off_i = 0;
        tick(2);
        chk("iq", torque_current_ref_o, 0);
        chk("ovr", torque_ref_override_o, 0);
    endtask
    task t_meas;
        wr(8'hee, 32'h0000_003f);
        chk("start", param_measure_start_o, 1);
        chk("shadow", measured_to_shadow_write_o, 1);
        tick(1);
        chk("shadow", measured_to_shadow_write_o, 0);
        // one enable at a time so a swapped pair shows up
        for (int i = 1; i < 5; i++) begin
            wr(8'hee, 32'h1 << i);
            chk("en", {measure_resistance_en_o, measure_inductance_en_o,
                measure_backemf_const_en_o, measure_mechanical_en_o},
                34'h1 << (i - 1));
            // strobe drops for one edge between writes
            tick(1);
        end
        measure_busy_i = 1;
        wr(8'hee, 32'h0000_0020);
        chk("start", param_measure_start_o, 0);
        tick(1);
        measure_busy_i = 0;
        ce_i = 0;
        wr(8'hee, 32'h0400_0000);
        ce_i = 1;
        rd_chk(8'hee, 32'h0000_0020);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        tick(21);
        rst_i = 0;
        rd_chk(8'hee, 32'h0000_0000);
        t_volt();
        t_torque();
        t_meas();
        report_and_stop();
    end
endmodule
bind motor_algo_debug_override_regs motor_dbg_sva chk_u (.*);
`default_nettype wire
